// >>> cmpmx_defs.svh
// constants for the comparator-1 mode / input-mux register block
// assumes an 8-bit special-function bus with one-cycle write and read strobes
// Behaviour
// (RL1) mode bit 7 reads one always
// (RL2) mode bits 6, 3:2 read zero
// (RL3) falling-edge interrupt only when its enable set
// (RL4) two-bit mode sets response versus power
// (RL5) per-comparator select register picks mux inputs
// (RL6) supply divider powered only while selected
// (RL7) comparator outputs routable to either timer
// (RL8) rising flag set by hardware, software clears
// (RL9) falling flag set by hardware, software clears
// (RL10) interrupt when any flag with enable set
`ifndef CMPMX_DEFS_SVH
`define CMPMX_DEFS_SVH

// ==========================================================
// register addresses
`define CMPMX_ADDR_CTRL   8'h9A
`define CMPMX_ADDR_ROUTE  8'h9B
`define CMPMX_ADDR_MODE   8'h9C
`define CMPMX_ADDR_SEL1   8'h9E
`define CMPMX_ADDR_SEL0   8'h9F

// ==========================================================
// reset values
`define CMPMX_MODE_RST    8'h82
`define CMPMX_SEL_RST     8'hFF
`define CMPMX_CTRL_RST    8'h00
`define CMPMX_ROUTE_RST   4'h0

// ==========================================================
// field positions
`define CMPMX_MODE_RSVD   7
`define CMPMX_MODE_RIE    5
`define CMPMX_MODE_FIE    4
`define CMPMX_CTRL_EN     7
`define CMPMX_CTRL_OUT    6
`define CMPMX_CTRL_RIF    5
`define CMPMX_CTRL_FIF    4
`define CMPMX_ROUTE_T2SRC 0
`define CMPMX_ROUTE_T2EN  1
`define CMPMX_ROUTE_T3SRC 2
`define CMPMX_ROUTE_T3EN  3

// ==========================================================
// mux code that selects the supply divided by two
`define CMPMX_DIV_CODE    4'hD

`endif

// >>> cmpmx_pkg.sv
// types shared by the comparator-1 mode / input-mux block
// assumes cmpmx_defs.svh supplies the numeric constants
package cmpmx_pkg;

  // ==========================================================
  // response time versus power modes
  typedef enum logic [1:0] {
    CMPMX_MODE_FAST = 2'h0,
    CMPMX_MODE_MID1 = 2'h1,
    CMPMX_MODE_MID2 = 2'h2,
    CMPMX_MODE_SLOW = 2'h3
  } cmpmx_mode_e;

  // input select pair of one comparator, as laid out in its register
  typedef struct packed {
    logic [3:0] neg;
    logic [3:0] pos;
  } cmpmx_sel_s;

endpackage

// >>> cmpmx_regs.sv
// comparator-1 mode, edge flags, interrupt and input-mux control registers
// assumes one-cycle sfr_wr / sfr_rd strobes on sys_clk; read data valid one cycle after sfr_rd
`timescale 1ns/100ps
`include "cmpmx_defs.svh"
module cmpmx_regs (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic [7:0]          sfr_addr,
  input  wire logic [7:0]          sfr_wdata,
  input  wire logic                sfr_wr,
  input  wire logic                sfr_rd,
  output logic [7:0]               sfr_rdata,
  input  wire logic                cmp0_async,
  input  wire logic                cmp1_async,
  output logic                     cmp1_irq,
  output logic                     cmp1_enable,
  output logic [3:0]               cmp1_hysteresis,
  output cmpmx_pkg::cmpmx_mode_e   response_power_mode,
  output cmpmx_pkg::cmpmx_sel_s    comparator0_input_select,
  output cmpmx_pkg::cmpmx_sel_s    comparator1_input_select,
  output logic                     divider_enable,
  output logic                     timer2_capture,
  output logic                     timer3_capture
);
  import cmpmx_pkg::*;

  // reset words held as typed constants so single fields can be picked out of them
  localparam logic [7:0] MODE_RST = `CMPMX_MODE_RST;
  localparam logic [7:0] CTRL_RST = `CMPMX_CTRL_RST;

  logic       rise_irq_enable;
  logic       fall_irq_enable;
  logic       rise_event_flag;
  logic       fall_event_flag;
  logic [3:0] timer_route;
  logic       cmp0_level;
  logic       cmp1_level;
  logic       cmp1_rise;
  logic       cmp1_fall;
  logic       wr_ctrl;
  logic       wr_mode;
  logic       wr_route;
  logic       wr_sel0;
  logic       wr_sel1;
  logic [7:0] next_rdata;

  // ==========================================================
  // helpers
  // true when either input of a comparator picks the supply divider
  function automatic logic picks_divider(input cmpmx_sel_s s);
    picks_divider = (s.pos == `CMPMX_DIV_CODE) || (s.neg == `CMPMX_DIV_CODE);
  endfunction

  // timer source: comparator 0 or 1, gated by the route enable
  function automatic logic route_pick(input logic en, input logic src, input logic c0, input logic c1);
    route_pick = en & (src ? c1 : c0);
  endfunction

  // ==========================================================
  // comparator output synchronisers
  cmpmx_sync_edge u_sync0 (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (cmp0_async),
    .level    (cmp0_level),
    .rise     (),
    .fall     ()
  );

  cmpmx_sync_edge u_sync1 (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (cmp1_async),
    .level    (cmp1_level),
    .rise     (cmp1_rise),
    .fall     (cmp1_fall)
  );

  // ==========================================================
  // address decode
  assign wr_ctrl  = sfr_wr && (sfr_addr == `CMPMX_ADDR_CTRL);
  assign wr_mode  = sfr_wr && (sfr_addr == `CMPMX_ADDR_MODE);
  assign wr_route = sfr_wr && (sfr_addr == `CMPMX_ADDR_ROUTE);
  assign wr_sel0  = sfr_wr && (sfr_addr == `CMPMX_ADDR_SEL0);
  assign wr_sel1  = sfr_wr && (sfr_addr == `CMPMX_ADDR_SEL1);

  // ==========================================================
  // mode register; bit 7 and unused bits are not stored at all
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rise_irq_enable     <= MODE_RST[`CMPMX_MODE_RIE];
      fall_irq_enable     <= MODE_RST[`CMPMX_MODE_FIE];
      response_power_mode <= cmpmx_mode_e'(MODE_RST[1:0]);
    end else if (wr_mode) begin
      rise_irq_enable     <= sfr_wdata[`CMPMX_MODE_RIE];
      fall_irq_enable     <= sfr_wdata[`CMPMX_MODE_FIE];
      response_power_mode <= cmpmx_mode_e'(sfr_wdata[1:0]); // RL4
    end
  end

  // control register: enable and hysteresis
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmp1_enable     <= CTRL_RST[`CMPMX_CTRL_EN];
      cmp1_hysteresis <= CTRL_RST[3:0];
    end else if (wr_ctrl) begin
      cmp1_enable     <= sfr_wdata[`CMPMX_CTRL_EN];
      cmp1_hysteresis <= sfr_wdata[3:0];
    end
  end

  // ==========================================================
  // edge flags; an edge in the clearing cycle wins so no event is lost
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rise_event_flag <= 1'b0;
    end else if (cmp1_rise) begin
      rise_event_flag <= 1'b1; // RL8
    end else if (wr_ctrl) begin
      rise_event_flag <= sfr_wdata[`CMPMX_CTRL_RIF]; // RL8
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fall_event_flag <= 1'b0;
    end else if (cmp1_fall) begin
      fall_event_flag <= 1'b1; // RL9
    end else if (wr_ctrl) begin
      fall_event_flag <= sfr_wdata[`CMPMX_CTRL_FIF]; // RL9
    end
  end

  // interrupt request, registered so the output comes from a flop
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmp1_irq <= 1'b0;
    end else begin
      cmp1_irq <= (rise_event_flag & rise_irq_enable) | (fall_event_flag & fall_irq_enable); // RL3 RL10
    end
  end

  // ==========================================================
  // input select registers, one per comparator
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      comparator0_input_select <= `CMPMX_SEL_RST;
    end else if (wr_sel0) begin
      comparator0_input_select <= sfr_wdata; // RL5
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      comparator1_input_select <= `CMPMX_SEL_RST;
    end else if (wr_sel1) begin
      comparator1_input_select <= sfr_wdata; // RL5
    end
  end

  // divider powered only while a mux selects it, saving its bias current
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      divider_enable <= 1'b0;
    end else begin
      divider_enable <= picks_divider(comparator0_input_select) || picks_divider(comparator1_input_select); // RL6
    end
  end

  // ==========================================================
  // timer routing; synchronised levels only, so timers never see metastability
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      timer_route <= `CMPMX_ROUTE_RST;
    end else if (wr_route) begin
      timer_route <= sfr_wdata[3:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      timer2_capture <= 1'b0;
      timer3_capture <= 1'b0;
    end else begin
      timer2_capture <= route_pick(timer_route[`CMPMX_ROUTE_T2EN], timer_route[`CMPMX_ROUTE_T2SRC],
                                   cmp0_level, cmp1_level); // RL7
      timer3_capture <= route_pick(timer_route[`CMPMX_ROUTE_T3EN], timer_route[`CMPMX_ROUTE_T3SRC],
                                   cmp0_level, cmp1_level); // RL7
    end
  end

  // ==========================================================
  // read mux; unmapped addresses read zero
  always_comb begin
    case (sfr_addr)
      `CMPMX_ADDR_MODE: begin
        next_rdata = {1'b1, 1'b0, rise_irq_enable, fall_irq_enable, 2'h0, response_power_mode}; // RL1 RL2
      end
      `CMPMX_ADDR_CTRL: begin
        next_rdata = {cmp1_enable, cmp1_level, rise_event_flag, fall_event_flag, cmp1_hysteresis};
      end
      `CMPMX_ADDR_ROUTE: begin
        next_rdata = {4'h0, timer_route};
      end
      `CMPMX_ADDR_SEL0: begin
        next_rdata = comparator0_input_select;
      end
      `CMPMX_ADDR_SEL1: begin
        next_rdata = comparator1_input_select;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // read data held until the next read strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata <= next_rdata;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  mode_top_one_a: assert property (sfr_rd && sfr_addr == `CMPMX_ADDR_MODE |=> sfr_rdata[7]) // RL1
    else $error("mode bit 7 did not read one");
  mode_unused_zero_a: assert property (sfr_rd && sfr_addr == `CMPMX_ADDR_MODE
                                       |=> !sfr_rdata[6] && sfr_rdata[3:2] == 2'h0) // RL2
    else $error("unused mode bits not zero");
  fall_irq_gate_a: assert property (fall_event_flag && !fall_irq_enable && !(rise_event_flag && rise_irq_enable)
                                    |=> !cmp1_irq) // RL3
    else $error("falling edge interrupt while disabled");
  mode_field_a: assert property (wr_mode |=> response_power_mode == $past(sfr_wdata[1:0])) // RL4
    else $error("mode field not written");
  sel_write_a: assert property (wr_sel1 |=> comparator1_input_select == $past(sfr_wdata)) // RL5
    else $error("input select not written");
  divider_gate_a: assert property (!picks_divider(comparator0_input_select)
                                   && !picks_divider(comparator1_input_select) |=> !divider_enable) // RL6
    else $error("divider on while not selected");
  timer2_route_a: assert property (timer_route[`CMPMX_ROUTE_T2EN] && timer_route[`CMPMX_ROUTE_T2SRC]
                                   |=> timer2_capture == $past(cmp1_level)) // RL7
    else $error("timer2 does not follow comparator 1");
  rise_set_a: assert property (cmp1_rise |=> rise_event_flag) // RL8
    else $error("rising edge not flagged");
  fall_set_a: assert property (cmp1_fall |=> fall_event_flag ##1 (cmp1_irq || !$past(fall_irq_enable))) // RL9
    else $error("falling edge not flagged");
  irq_raise_a: assert property (rise_event_flag && rise_irq_enable |=> cmp1_irq) // RL10
    else $error("rising interrupt not raised");

  rise_irq_c: cover property (cmp1_rise ##1 rise_event_flag && rise_irq_enable ##1 cmp1_irq);
  clear_race_c: cover property (cmp1_fall && wr_ctrl && !sfr_wdata[`CMPMX_CTRL_FIF]);
  divider_on_c: cover property (wr_sel0 ##1 divider_enable);

endmodule

// >>> cmpmx_sync_edge.sv
// synchroniser and edge detector for one asynchronous comparator output
// assumes the input is an analog comparator level with no relation to sys_clk
`timescale 1ns/100ps
module cmpmx_sync_edge (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic async_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta;
  logic prev;

  // ==========================================================
  // two-flop synchroniser; meta feeds only the second flop
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta  <= 1'b0;
      level <= 1'b0;
    end else begin
      meta  <= async_in;
      level <= meta;
    end
  end

  // previous synchronised level for edge detection
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prev <= 1'b0;
    end else begin
      prev <= level;
    end
  end

  // one-cycle pulses, combinational from flops only
  assign rise = level & ~prev;
  assign fall = ~level & prev;

endmodule

// >>> comparator1_mode_irq_regs_tb.sv
// self-checking bench for the comparator-1 mode, edge flag and input-mux registers
// assumes cmpmx_regs with one-cycle sfr strobes and read data valid after the read edge
`timescale 1ns/100ps
`include "cmpmx_defs.svh"
module comparator1_mode_irq_regs_tb;
  import cmpmx_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic        sys_clk    = 1'b0;
  logic        rst        = 1'b1;
  logic [7:0]  sfr_addr   = 8'h00;
  logic [7:0]  sfr_wdata  = 8'h00;
  logic        sfr_wr     = 1'b0;
  logic        sfr_rd     = 1'b0;
  logic        cmp0_async = 1'b0;
  logic        cmp1_async = 1'b0;
  logic [7:0]  sfr_rdata;
  logic        cmp1_irq;
  logic        cmp1_enable;
  logic [3:0]  cmp1_hysteresis;
  cmpmx_mode_e response_power_mode;
  cmpmx_sel_s  comparator0_input_select;
  cmpmx_sel_s  comparator1_input_select;
  logic        divider_enable;
  logic        timer2_capture;
  logic        timer3_capture;
  int          fail_count = 0;
  int          compares   = 0;

  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;

  cmpmx_regs u_cmpmx_regs (
    .sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .cmp0_async(cmp0_async), .cmp1_async(cmp1_async),
    .cmp1_irq(cmp1_irq), .cmp1_enable(cmp1_enable), .cmp1_hysteresis(cmp1_hysteresis),
    .response_power_mode(response_power_mode), .comparator0_input_select(comparator0_input_select),
    .comparator1_input_select(comparator1_input_select), .divider_enable(divider_enable),
    .timer2_capture(timer2_capture), .timer3_capture(timer3_capture)
  );

  // ==========================================================
  // reporting
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ==========================================================
  // bus cycles; every change lands 2 ns after a rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    cyc(1);
    sfr_wr = 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    cyc(1);
    sfr_addr = a;
    sfr_rd = 1'b1;
    cyc(1);
    sfr_rd = 1'b0;
    chk(what, exp, sfr_rdata);
  endtask

  // bounded wait; a level that never shows is counted as a mismatch
  task automatic wait_irq(input logic exp);
    int i;
    for (i = 0; i < 8 && cmp1_irq !== exp; i++) cyc(1);
    chk("cmp1_irq", {7'h0, exp}, {7'h0, cmp1_irq});
  endtask

  // ==========================================================
  // expectations
  function automatic logic [7:0] mode_exp(input logic [7:0] d);
    return 8'h80 | (d & 8'h33);
  endfunction

  function automatic logic route_exp(input logic en, input logic src, input logic c0, input logic c1);
    return en & (src ? c1 : c0);
  endfunction

  function automatic logic div_exp(input logic [7:0] s0, input logic [7:0] s1);
    return s0[7:4] == `CMPMX_DIV_CODE || s0[3:0] == `CMPMX_DIV_CODE ||
           s1[7:4] == `CMPMX_DIV_CODE || s1[3:0] == `CMPMX_DIV_CODE;
  endfunction

  // watchdog; far beyond the few hundred cycles the sequence needs
  initial begin
    #500000;
    fail_count++;
    give_verdict();
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] d;
    logic [7:0] s0;
    logic [7:0] s1;
    int         i;
    int         seed;
    seed = $urandom(32'hdaffe604);
    cyc(6);
    rst = 1'b0;
    // reset values
    rd_chk("mode", `CMPMX_ADDR_MODE, 8'h82);
    rd_chk("sel0", `CMPMX_ADDR_SEL0, 8'hFF);
    rd_chk("sel1", `CMPMX_ADDR_SEL1, 8'hFF);
    rd_chk("ctrl", `CMPMX_ADDR_CTRL, 8'h00);
    // every mode code, random fixed and unused bits
    for (i = 0; i < 8; i++) begin
      d = 8'($urandom);
      if (i < 4) d[1:0] = 2'(i);
      wr(`CMPMX_ADDR_MODE, d);
      chk("mode_out", {6'h0, d[1:0]}, {6'h0, response_power_mode});
      rd_chk("mode", `CMPMX_ADDR_MODE, mode_exp(d));
    end
    wr(8'h9D, 8'($urandom));
    rd_chk("unmapped", 8'h9D, 8'h00);
    // selects; first two carry the divider code, last four cannot
    for (i = 0; i < 8; i++) begin
      s0 = 8'($urandom);
      s1 = 8'($urandom);
      if (i == 0) s0[3:0] = `CMPMX_DIV_CODE;
      if (i == 1) s1[7:4] = `CMPMX_DIV_CODE;
      if (i > 3) s0 = s0 & 8'h77;
      if (i > 3) s1 = s1 & 8'h77;
      wr(`CMPMX_ADDR_SEL0, s0);
      wr(`CMPMX_ADDR_SEL1, s1);
      cyc(1);
      chk("sel0_out", s0, comparator0_input_select);
      chk("sel1_out", s1, comparator1_input_select);
      chk("divider", {7'h0, div_exp(s0, s1)}, {7'h0, divider_enable});
      rd_chk("sel1", `CMPMX_ADDR_SEL1, s1);
    end
    // timer routing, all source pairs enabled first, then random
    for (i = 0; i < 8; i++) begin
      d = 8'($urandom);
      if (i < 4) d[3:0] = {1'b1, 1'(i >> 1), 1'b1, 1'(i)};
      cmp0_async = d[4];
      cmp1_async = d[5];
      wr(`CMPMX_ADDR_ROUTE, {4'h0, d[3:0]});
      cyc(6);
      chk("timer2", {7'h0, route_exp(d[1], d[0], d[4], d[5])}, {7'h0, timer2_capture});
      chk("timer3", {7'h0, route_exp(d[3], d[2], d[4], d[5])}, {7'h0, timer3_capture});
    end
    // edge flags and interrupt gating
    cmp1_async = 1'b0;
    wr(`CMPMX_ADDR_MODE, 8'h80);
    cyc(6);
    wr(`CMPMX_ADDR_CTRL, 8'h00);
    cmp1_async = 1'b1;
    cyc(8);
    chk("irq_off", 8'h00, {7'h0, cmp1_irq});
    rd_chk("ctrl", `CMPMX_ADDR_CTRL, 8'h60);
    wr(`CMPMX_ADDR_MODE, 8'hA0);
    wait_irq(1'b1);
    wr(`CMPMX_ADDR_CTRL, 8'h00);
    wait_irq(1'b0);
    rd_chk("ctrl", `CMPMX_ADDR_CTRL, 8'h40);
    cmp1_async = 1'b0;
    cyc(8);
    chk("irq_fall_off", 8'h00, {7'h0, cmp1_irq});
    rd_chk("ctrl", `CMPMX_ADDR_CTRL, 8'h10);
    wr(`CMPMX_ADDR_MODE, 8'h90);
    wait_irq(1'b1);
    wr(`CMPMX_ADDR_CTRL, 8'h00);
    wait_irq(1'b0);
    rd_chk("ctrl", `CMPMX_ADDR_CTRL, 8'h00);
    // enable and hysteresis fields; flags written as zero must stay clear
    for (i = 0; i < 4; i++) begin
      d = 8'($urandom) & 8'h8F;
      if (i == 0) d = 8'h8F;
      wr(`CMPMX_ADDR_CTRL, d);
      chk("enable", {7'h0, d[7]}, {7'h0, cmp1_enable});
      chk("hysteresis", {4'h0, d[3:0]}, {4'h0, cmp1_hysteresis});
      rd_chk("ctrl", `CMPMX_ADDR_CTRL, d);
    end
    give_verdict();
  end
endmodule
